// *** common/sarc_pkg.sv ***
// Purpose: Shared constants and types of the converter frame control.
// Assumes: Falls are counted from 1 inside a frame opened by chip select going low.
// Notes:   All fall numbers are compared against the count after it is bumped.
package sarc_pkg;

   localparam int RES_W = 12;
   localparam int CNT_W = 6;

   localparam logic [CNT_W-1:0] CONV_LAST_FALL = 6'h0c;
   localparam logic [CNT_W-1:0] DATA_FIRST_FALL = 6'h02;
   localparam logic [CNT_W-1:0] DATA_LAST_FALL = 6'h0d;
   localparam logic [CNT_W-1:0] PU_CAL_STEP_LAST = 6'h0c;
   localparam logic [CNT_W-1:0] PU_CAL_DONE = 6'h10;
   localparam logic [CNT_W-1:0] NORM_CAL_START = 6'h11;
   localparam logic [CNT_W-1:0] NORM_CAL_STEP_LAST = 6'h1d;
   localparam logic [CNT_W-1:0] NORM_CAL_DONE = 6'h20;
   localparam logic [CNT_W-1:0] FALL_MAX = 6'h3f;

   localparam logic [RES_W-1:0] OFFSET_RESET = 12'h000;
   localparam logic [RES_W-1:0] CODE_FULL = 12'hfff;

   typedef enum logic [1:0] {
      SARC_ACQ = 2'b00,
      SARC_CONV = 2'b01,
      SARC_POST = 2'b10,
      SARC_CAL = 2'b11
   } sarc_state_t;

endpackage

// *** common/sarc_sar_if.sv ***
// Purpose: Carries the controls and code between frame control and the search engine.
// Assumes: One clock domain; start and step are one-cycle pulses.
// Notes:   The comparator level is passed through unchanged.
interface sarc_sar_if #(parameter int W = 12);
   logic start;
   logic step;
   logic comp;
   logic busy;
   logic [W-1:0] code;
   logic [W-1:0] trial;

   modport ctl (output start, output step, output comp, input busy, input code, input trial);
   modport eng (input start, input step, input comp, output busy, output code, output trial);
endinterface

// *** hw/sarc_frame_ctrl.sv ***
// Purpose: Frame control of a 12-bit successive-approximation converter.
// Assumes: cs_n_i and sclk_i are synchronous to clock_i, which must run
//          well above twice the serial clock so that every fall is seen.
// Notes:   rst_i stands for power-up; it clears the offset store and arms
//          the power-up calibration.
module sarc_frame_ctrl (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Serial interface
   input wire logic cs_n_i,
   input wire logic sclk_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Analog core
   input wire logic comp_i,
   output logic sample_o,
   output logic input_connect_o,
   output logic [sarc_pkg::RES_W-1:0] dac_code_o,
   // Status
   output logic cal_busy_o,
   output logic [sarc_pkg::RES_W-1:0] offset_o
);
   import sarc_pkg::*;

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   logic cs_q;
   logic sclk_q;
   logic cs_fall;
   logic cs_rise;
   logic sck_fall;

   assign cs_fall = cs_q & ~cs_n_i;
   assign cs_rise = ~cs_q & cs_n_i;
   assign sck_fall = sclk_q & ~sclk_i & ~cs_n_i & ~cs_q;

   // ----------------------------------------------------------------
   // Search engine
   // ----------------------------------------------------------------
   sarc_sar_if #(.W(RES_W)) sar ();

   sarc_sar_engine #(.WIDTH(RES_W)) u_engine (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .sar(sar)
   );

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------
   sarc_state_t state;
   sarc_state_t next_state;
   logic [CNT_W-1:0] falls;
   logic [CNT_W-1:0] next_falls;
   logic [CNT_W-1:0] nf;
   logic pu_pending;
   logic next_pu_pending;
   logic cal_norm;
   logic next_cal_norm;
   logic [RES_W-1:0] offset;
   logic [RES_W-1:0] next_offset;
   logic next_sdo;
   logic next_sdo_oe;
   logic next_sample;
   logic next_connect;
   logic next_cal_busy;
   logic [RES_W-1:0] next_dac;
   logic [RES_W:0] dac_sum;
   logic start;
   logic step;

   assign nf = (falls == FALL_MAX) ? falls : falls + 1'b1;
   assign sar.start = start;
   assign sar.step = step;
   assign sar.comp = comp_i;
   assign dac_sum = {1'b0, sar.trial} + {1'b0, offset};

   always_comb begin
      next_state = state;
      next_falls = falls;
      next_pu_pending = pu_pending;
      next_cal_norm = cal_norm;
      next_offset = offset;
      next_sample = 1'b0;
      start = 1'b0;
      step = 1'b0;
      if (cs_fall) begin
         next_falls = '0;
         next_sample = 1'b1;
         start = 1'b1;
         next_pu_pending = 1'b0;
         next_cal_norm = 1'b0;
         next_state = pu_pending ? SARC_CAL : SARC_CONV;
      end else if (cs_rise) begin
         // An unfinished calibration is dropped and the store kept.
         next_state = SARC_ACQ;
      end else if (sck_fall) begin
         next_falls = nf;
         unique case (state)
            SARC_CONV: begin
               step = 1'b1;
               if (nf == CONV_LAST_FALL) begin
                  next_state = SARC_POST;
               end
            end
            SARC_POST: begin
               if (nf == NORM_CAL_START) begin
                  start = 1'b1;
                  next_cal_norm = 1'b1;
                  next_state = SARC_CAL;
               end
            end
            SARC_CAL: begin
               if (cal_norm) begin
                  step = (nf > NORM_CAL_START) && (nf <= NORM_CAL_STEP_LAST);
                  if (nf == NORM_CAL_DONE) begin
                     next_offset = sar.code;
                     next_state = SARC_POST;
                  end
               end else begin
                  step = nf <= PU_CAL_STEP_LAST;
                  if (nf == PU_CAL_DONE) begin
                     next_offset = sar.code;
                     next_state = SARC_POST;
                  end
               end
            end
            SARC_ACQ: begin
               next_state = SARC_ACQ;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------
   always_comb begin
      next_sdo = sdo_o;
      next_sdo_oe = sdo_oe_o;
      if (cs_fall) begin
         next_sdo = 1'b0;
         next_sdo_oe = 1'b1;
      end else if (cs_rise) begin
         next_sdo = 1'b0;
         next_sdo_oe = 1'b0;
      end else if (sck_fall) begin
         // Two zeros lead, the result follows, and the line stays low after.
         if (!cal_norm && state != SARC_CAL && nf >= DATA_FIRST_FALL
             && nf <= DATA_LAST_FALL) begin
            next_sdo = sar.code[4'(DATA_LAST_FALL - nf)];
         end else begin
            next_sdo = 1'b0;
         end
      end
   end

   // The sampler is isolated while converting or calibrating.
   always_comb begin
      next_connect = (next_state == SARC_ACQ) || (next_state == SARC_POST);
      next_cal_busy = (next_state == SARC_CAL);
   end

   // The search in a conversion is shifted by the stored offset, saturating
   // at full scale, so the result is already corrected.
   always_comb begin
      if (state == SARC_CAL) begin
         next_dac = sar.trial;
      end else if (dac_sum[RES_W]) begin
         next_dac = CODE_FULL;
      end else begin
         next_dac = dac_sum[RES_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Edge history starts at the idle levels so no false edge follows reset.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cs_q <= 1'b1;
         sclk_q <= 1'b0;
      end else begin
         cs_q <= cs_n_i;
         sclk_q <= sclk_i;
      end
   end

   // Frame sequencing state and the offset store.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state <= SARC_ACQ;
         falls <= '0;
         pu_pending <= 1'b1;
         cal_norm <= 1'b0;
         offset <= OFFSET_RESET;
      end else begin
         state <= next_state;
         falls <= next_falls;
         pu_pending <= next_pu_pending;
         cal_norm <= next_cal_norm;
         offset <= next_offset;
      end
   end

   // Output registers, so every pin comes straight from a flip-flop.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
         sample_o <= 1'b0;
         input_connect_o <= 1'b1;
         dac_code_o <= '0;
         cal_busy_o <= 1'b0;
         offset_o <= OFFSET_RESET;
      end else begin
         sdo_o <= next_sdo;
         sdo_oe_o <= next_sdo_oe;
         sample_o <= next_sample;
         input_connect_o <= next_connect;
         dac_code_o <= next_dac;
         cal_busy_o <= next_cal_busy;
         offset_o <= next_offset;
      end
   end
endmodule

// *** hw/sarc_sar_engine.sv ***
// Purpose: Successive-approximation search, one bit decided per step pulse.
// Assumes: comp is high while the held sample is at or above the trial level.
// Notes:   Bits are decided most significant first; busy drops after the last one.
module sarc_sar_engine #(
   parameter int WIDTH = sarc_pkg::RES_W
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Link to frame control
   sarc_sar_if.eng sar
);
   import sarc_pkg::*;

   localparam int PW = $clog2(WIDTH);
   localparam logic [PW-1:0] PTR_TOP = PW'(WIDTH - 1);

   logic [WIDTH-1:0] code;
   logic [WIDTH-1:0] next_code;
   logic [PW-1:0] ptr;
   logic [PW-1:0] next_ptr;
   logic busy;
   logic next_busy;
   logic [WIDTH-1:0] mask;

   assign mask = busy ? ({{(WIDTH-1){1'b0}}, 1'b1} << ptr) : '0;
   assign sar.trial = code | mask;
   assign sar.code = code;
   assign sar.busy = busy;

   always_comb begin
      next_code = code;
      next_ptr = ptr;
      next_busy = busy;
      if (sar.start) begin
         next_code = '0;
         next_ptr = PTR_TOP;
         next_busy = 1'b1;
      end else if (sar.step && busy) begin
         // Keep the trial bit only when the sample is not below the trial level.
         next_code[ptr] = sar.comp;
         if (ptr == '0) begin
            next_busy = 1'b0;
         end else begin
            next_ptr = ptr - 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         code <= '0;
         ptr <= '0;
         busy <= 1'b0;
      end else begin
         code <= next_code;
         ptr <= next_ptr;
         busy <= next_busy;
      end
   end
endmodule

// *** test/sarc_frame_ctrl_monitor.sv ***
// Purpose: Port checks of the converter frame control.
// Assumes: Inputs are synchronous to clock_i.
// Notes:   Bound from the bench top.
module sarc_frame_ctrl_monitor (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Watched ports
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic sdo_o,
   input wire logic sdo_oe_o,
   input wire logic comp_i,
   input wire logic sample_o,
   input wire logic input_connect_o,
   input wire logic [sarc_pkg::RES_W-1:0] dac_code_o,
   input wire logic cal_busy_o,
   input wire logic [sarc_pkg::RES_W-1:0] offset_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence cs_fall;
      $fell(cs_n_i);
   endsequence
   sequence frame_open;
      cs_fall ##1 sdo_oe_o;
   endsequence
   cs_sample_a: assert property (cs_fall |=> sample_o)
      else $error("sample missing");
   sample_pulse_a: assert property (sample_o |=> !sample_o)
      else $error("sample too long");
   sample_isolate_a: assert property (sample_o |-> !input_connect_o)
      else $error("inputs connected");
   oe_open_a: assert property (cs_fall |=> sdo_oe_o)
      else $error("output not driven");
   oe_release_a: assert property ($rose(cs_n_i) |=> !sdo_oe_o)
      else $error("output not released");
   first_zero_a: assert property (frame_open |-> !sdo_o)
      else $error("first bit high");
   cal_low_a: assert property (cal_busy_o |-> !sdo_o)
      else $error("data high in calibration");
   offset_hold_a: assert property ($changed(offset_o) |-> $past(cal_busy_o))
      else $error("offset changed outside calibration");
   cal_isolate_a: assert property (cal_busy_o |-> !input_connect_o)
      else $error("inputs connected in calibration");
endmodule

// *** test/sarc_frame_ctrl_tb_top.sv ***
// Purpose: Self-checking bench of the converter frame control.
// Assumes: The comparator sees the held sample, or the offset while calibrating.
// Notes:   Random samples come from a fixed-seed shift register.
module sarc_frame_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sarc_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic comp_i = 1'b0;
   logic cs_n_i, sclk_i, sdo_o, sdo_oe_o, sample_o, input_connect_o, cal_busy_o;
   logic [RES_W-1:0] dac_code_o, offset_o;
   logic [RES_W-1:0] smp = 12'h000;
   logic [RES_W-1:0] held = 12'h000;
   logic [RES_W-1:0] off_v = 12'h005;
   logic [13:0] word;
   logic [31:0] rnd = 32'd90966;
   int n_mismatch = 0;
   int compares = 0;

   sarc_frame_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
      .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .comp_i(comp_i), .sample_o(sample_o),
      .input_connect_o(input_connect_o), .dac_code_o(dac_code_o), .cal_busy_o(cal_busy_o),
      .offset_o(offset_o));
   sarc_host_model u_host (.clock_i(clock_i), .sdo_i(sdo_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i));

   initial begin
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (sample_o) held <= smp;
      comp_i <= ((cal_busy_o ? off_v : held) >= dac_code_o);
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [13:0] exp_word(input logic [11:0] s, input logic [11:0] o);
      if (s == CODE_FULL) return {2'b00, CODE_FULL};
      return (s >= o) ? {2'b00, s - o} : 14'h0000;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      chk(16'(offset_o), 16'(OFFSET_RESET));
      u_host.frame(16, word);
      chk(16'(word), 16'h0000);
      chk(16'(offset_o), 16'(off_v));
      off_v = 12'h009;
      u_host.frame(31, word);
      chk(16'(offset_o), 16'h0005);
      chk(16'(cal_busy_o), 16'h0000);
      u_host.frame(32, word);
      chk(16'(offset_o), 16'(off_v));
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         smp = (i == 0) ? 12'h000 : (i == 1) ? CODE_FULL : (i == 2) ? off_v : rnd[11:0];
         u_host.frame(14 + i % 3, word);
         chk(16'(word), 16'(exp_word(smp, off_v)));
         chk(16'(sdo_oe_o), 16'h0000);
         chk(16'(input_connect_o), 16'h0001);
         chk(16'(cal_busy_o), 16'h0000);
         chk(16'(offset_o), 16'(off_v));
      end
      conclude();
   end
endmodule

bind sarc_frame_ctrl sarc_frame_ctrl_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i),
   .cs_n_i(cs_n_i), .sclk_i(sclk_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .comp_i(comp_i),
   .sample_o(sample_o), .input_connect_o(input_connect_o), .dac_code_o(dac_code_o),
   .cal_busy_o(cal_busy_o), .offset_o(offset_o));

// *** test/sarc_host_model.sv ***
// Purpose: Host that frames conversions with chip select and serial clock.
// Assumes: Each level holds four system clocks, a 2.5 MHz serial clock.
// Notes:   The serial clock rests low between frames.
module sarc_host_model (
   // System clock
   input wire logic clock_i,
   // Serial link
   input wire logic sdo_i,
   output logic cs_n_o = 1'b1,
   output logic sclk_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   task automatic frame(input int n, output logic [13:0] b);
      b = 14'h0000;
      @(posedge clock_i);
      cs_n_o <= 1'b0;
      for (int k = 0; k < n; k++) begin
         repeat (4) @(posedge clock_i);
         if (k < 14) b[13-k] = sdo_i;
         // The serial clock is scaled to the system clock that samples it.
         sclk_o <= 1'b1;
         repeat (4) @(posedge clock_i);
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clock_i);
      cs_n_o <= 1'b1;
      repeat (8) @(posedge clock_i);
   endtask
endmodule
